// ===== data_memory_model.sv
// Purpose: Data memory on the far side of the datapath.
// Assumes: Operand byte read at once; writes land one edge later.
// Notes:   The write address is latched at issue, because the write
//          pulse arrives one cycle after the operation is taken.
module data_memory_model (
    // Clock and issue.
    input  wire logic       core_clk,
    input  wire logic       opIssue,
    // Address and data.
    input  wire logic [3:0] addr,
    input  wire logic       memWrEn,
    input  wire logic [7:0] memWrData,
    output logic      [7:0] memData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [16]; // Storage bytes.
    logic [3:0] wrAddr;   // Address of the operation in flight.
    assign memData = mem[addr];
    // Latch the address at issue and store the write pulse.
    always @(posedge core_clk) begin
        if (opIssue) begin
            wrAddr <= addr;
        end
        if (memWrEn) begin
            mem[wrAddr] <= memWrData;
        end
    end
endmodule

// ===== rotate_subtract_skip_alu.sv
// Purpose: Rotate, subtract, step-and-skip, set and swap datapath of an
//          8-bit core, with accumulator and flags reachable over APB.
// Assumes: Inputs synchronous to core_clk; memory byte presented with the
//          operation; memory write performed by the caller on memWrEn.
// Notes:   One operation per cycle; skip operations hold off the next
//          issue for one extra cycle.
`include "rotate_subtract_skip_alu_defines.svh"

// Overview of operation
// RULE_01: Rotate left, bit 7 into bit 0.
// RULE_02: Rotate left through carry, carry updated only.
// RULE_03: Rotate right, bit 0 into bit 7.
// RULE_04: Rotate right through carry, carry updated only.
// RULE_05: Accumulator minus memory minus inverted carry.
// RULE_06: Same with immediate operand, six flags.
// RULE_07: Borrow subtract to memory, accumulator kept.
// RULE_08: Carry clear on negative, set otherwise.
// RULE_09: Plain subtract to accumulator or memory.
// RULE_10: Decrement memory, skip when zero.
// RULE_11: Decrement into accumulator, skip when zero.
// RULE_12: Increment memory, skip when zero.
// RULE_13: Increment into accumulator, skip when zero.
// RULE_14: Skip operations take two cycles, dummy inserted.
// RULE_15: Set byte writes all ones.
// RULE_16: Set bit forces one selected bit.
// RULE_17: Skip when byte or bit non-zero.
// RULE_18: Swap low and high nibbles.
// RULE_19: Swap writes memory, flags untouched.
// RULE_20: Zero flag and arithmetic flags usual meaning.
module rotate_subtract_skip_alu (
    // Clock, reset and freeze.
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic                          clkEn,
    // Operation from the instruction decoder.
    input  wire logic                          opValid,
    input  wire rotate_subtract_skip_alu_pkg::op_t opCode,
    input  wire logic                          opToAcc,
    input  wire logic                          opImm,
    input  wire logic [2:0]                    bitSel,
    input  wire logic [7:0]                    memData,
    input  wire logic [7:0]                    immData,
    output logic                               opReady,
    // Results towards data memory and the sequencer.
    output logic                               memWrEn,
    output logic [7:0]                         memWrData,
    output logic                               skipNext,
    output logic                               dummyIns,
    output logic [7:0]                         accumulatorReg,
    output logic [5:0]                         flags,
    // APB slave.
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr
);
    import rotate_subtract_skip_alu_pkg::*;

    // Reset value of the whole state record.
    localparam alu_state_t RESET_ST = '{
        phase:          PH_ISSUE,
        accumulatorReg: `RST_ACCUMULATOR,
        flags:          `RST_FLAGS,
        enable:         `RST_ENABLE,
        skipCount:      `RST_SKIP_COUNT,
        memWrEn:        1'h0,
        memWrData:      `BYTE_ZERO,
        skipNext:       1'h0,
        dummyIns:       1'h0,
        opReady:        1'h1,
        pready:         1'h0,
        prdata:         `WORD_ZERO,
        pslverr:        1'h0
    };

    logic [1:0] rstPipe;   // Reset release synchroniser.
    logic       rstSync;   // Synchronised active-low reset.
    alu_state_t st;        // Registered state.
    alu_state_t next_st;   // Next state from the combinational process.
    logic       issue;     // An operation is accepted this cycle.
    logic       apbDone;   // An APB access completes this cycle.

    // Subtraction with flag calculation; returns {flags, difference}.
    // The chain input lets the borrow form accumulate the combined zero.
    function automatic logic [13:0] subCalc(
        input logic [7:0]             a,
        input logic [7:0]             b,
        input logic                   bin,
        input logic [`FLAG_WIDTH-1:0] f,
        input logic                   chain
    );
        logic [8:0]             d;
        logic [4:0]             lo;
        logic [`FLAG_WIDTH-1:0] nf;
        d  = {1'h0, a} - {1'h0, b} - {8'h00, bin};
        lo = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, bin};
        nf = f;
        nf[`FLAG_CARRY]        = ~d[8];                  // see RULE_08
        nf[`FLAG_AUX_CARRY]    = ~lo[4];                 // see RULE_20
        nf[`FLAG_ZERO]         = (d[7:0] == `BYTE_ZERO); // see RULE_20
        nf[`FLAG_OVERFLOW]     = (a[7] ^ b[7]) & (d[7] ^ a[7]);
        nf[`FLAG_SIGNED_CARRY] = nf[`FLAG_OVERFLOW] ^ d[7];
        nf[`FLAG_COMB_ZERO]    = chain ?
            (nf[`FLAG_ZERO] & f[`FLAG_COMB_ZERO]) : nf[`FLAG_ZERO];
        return {nf, d[7:0]};
    endfunction

    // Reset release: assert at once, release after two clean edges.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'h1};
        end
    end
    assign rstSync = rstPipe[1];

    // An access finishes on the edge where our registered ready is seen.
    assign apbDone = psel & penable & st.pready;
    // Operations are taken only while enabled and not in a second cycle.
    assign issue   = opValid & st.opReady & st.enable;

    // Next-state logic: APB first, then the operation, which wins on a
    // collision because the running program owns the accumulator.
    always_comb begin
        logic [13:0] sub;
        logic [7:0]  operand;
        logic [7:0]  res;
        logic        skipOp;
        logic        skipTaken;
        logic        toMem;
        sub       = 14'h0000;
        operand   = opImm ? immData : memData;
        res       = memData;
        skipOp    = 1'h0;
        skipTaken = 1'h0;
        toMem     = ~opToAcc;
        next_st   = st;

        // Pulses drop unless renewed below.
        next_st.memWrEn  = 1'h0;
        next_st.skipNext = 1'h0;

        // APB slave: one wait cycle, then a registered answer.
        next_st.pready  = psel & penable & ~st.pready;
        next_st.pslverr = 1'h0;
        if (psel & penable & ~st.pready) begin
            next_st.prdata = `WORD_ZERO;
            unique case (paddr)
                `OFS_ACCUMULATOR: begin
                    next_st.prdata[7:0] = st.accumulatorReg;
                end
                `OFS_FLAGS: begin
                    next_st.prdata[`FLAG_WIDTH-1:0] = st.flags;
                end
                `OFS_CONTROL: begin
                    next_st.prdata[`CTRL_ENABLE] = st.enable;
                end
                `OFS_SKIP_COUNT: begin
                    next_st.prdata[7:0] = st.skipCount;
                end
                default: begin
                    // Unmapped words read zero and report an error.
                    next_st.pslverr = 1'h1;
                end
            endcase
        end
        if (apbDone & pwrite) begin
            // The skip counter is read-only; writes to it are dropped.
            unique case (paddr)
                `OFS_ACCUMULATOR: begin
                    next_st.accumulatorReg = pwdata[7:0];
                end
                `OFS_FLAGS: begin
                    next_st.flags = pwdata[`FLAG_WIDTH-1:0];
                end
                `OFS_CONTROL: begin
                    next_st.enable = pwdata[`CTRL_ENABLE];
                end
                default: begin
                    next_st.enable = next_st.enable;
                end
            endcase
        end

        // Sequencer: the second cycle of a skip operation.
        unique case (st.phase)
            PH_ISSUE: begin
                next_st.dummyIns = 1'h0;
            end
            PH_SECOND: begin
                // The slot of the skipped instruction is over.
                next_st.phase    = PH_ISSUE;
                next_st.opReady  = 1'h1;
                next_st.dummyIns = 1'h0;
            end
        endcase

        if (issue) begin
            unique case (opCode)
                OP_ROTATE_LEFT: begin
                    res = {memData[6:0], memData[7]};       // see RULE_01
                end
                OP_ROTATE_LEFT_C: begin
                    res = {memData[6:0], st.flags[`FLAG_CARRY]};
                    next_st.flags[`FLAG_CARRY] = memData[7]; // see RULE_02
                end
                OP_ROTATE_RIGHT: begin
                    res = {memData[0], memData[7:1]};       // see RULE_03
                end
                OP_ROTATE_RIGHT_C: begin
                    res = {st.flags[`FLAG_CARRY], memData[7:1]};
                    next_st.flags[`FLAG_CARRY] = memData[0]; // see RULE_04
                end
                OP_SUBTRACT_BORROW: begin
                    // Borrow in is the inverted carry.  see RULE_05 RULE_06
                    sub = subCalc(st.accumulatorReg, operand,
                                  ~st.flags[`FLAG_CARRY], st.flags, 1'h1);
                    res = sub[7:0];
                    next_st.flags = sub[13:8];
                    toMem = ~opToAcc & ~opImm;               // see RULE_07
                end
                OP_SUBTRACT_PLAIN: begin
                    sub = subCalc(st.accumulatorReg, operand,
                                  1'h0, st.flags, 1'h0);      // see RULE_09
                    res = sub[7:0];
                    next_st.flags = sub[13:8];
                    toMem = ~opToAcc & ~opImm;
                end
                OP_DECREMENT_SKIP: begin
                    res       = memData - `BYTE_ONE;  // see RULE_10 RULE_11
                    skipOp    = 1'h1;
                    skipTaken = (res == `BYTE_ZERO);
                end
                OP_INCREMENT_SKIP: begin
                    res       = memData + `BYTE_ONE;  // see RULE_12 RULE_13
                    skipOp    = 1'h1;
                    skipTaken = (res == `BYTE_ZERO);
                end
                OP_SET_BYTE: begin
                    res   = `BYTE_ALL_ONES;                 // see RULE_15
                    toMem = 1'h1;
                end
                OP_SET_BIT: begin
                    res         = memData;
                    res[bitSel] = 1'h1;                     // see RULE_16
                    toMem       = 1'h1;
                end
                OP_SKIP_NZ_BYTE: begin
                    skipOp    = 1'h1;
                    skipTaken = (memData != `BYTE_ZERO);    // see RULE_17
                    toMem     = 1'h0;
                end
                OP_SKIP_NZ_BIT: begin
                    skipOp    = 1'h1;
                    skipTaken = memData[bitSel];            // see RULE_17
                    toMem     = 1'h0;
                end
                OP_SWAP_NIBBLES: begin
                    res   = {memData[3:0], memData[7:4]};   // see RULE_18
                    toMem = 1'h1;                           // see RULE_19
                end
                default: begin
                    // A code outside the set loads the memory byte into the accumulator.
                    toMem = 1'h0;
                end
            endcase

            // Destination: memory write pulse or accumulator load.
            if ((opCode == OP_SKIP_NZ_BYTE) || (opCode == OP_SKIP_NZ_BIT)
                || (opCode == OP_NONE)) begin
                next_st.memWrEn = 1'h0;
            end else if (toMem) begin
                next_st.memWrEn   = 1'h1;
                next_st.memWrData = res;
            end else begin
                next_st.accumulatorReg = res;
            end

            // Skip operations occupy two cycles.  see RULE_14
            if (skipOp) begin
                next_st.phase    = PH_SECOND;
                next_st.opReady  = 1'h0;
                next_st.skipNext = skipTaken;
                next_st.dummyIns = skipTaken;
                if (skipTaken) begin
                    next_st.skipCount = st.skipCount + `BYTE_ONE;
                end
            end
        end
    end

    // Single state register; frozen while the clock enable is low.
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            st <= RESET_ST;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state record.
    assign opReady        = st.opReady;
    assign memWrEn        = st.memWrEn;
    assign memWrData      = st.memWrData;
    assign skipNext       = st.skipNext;
    assign dummyIns       = st.dummyIns;
    assign accumulatorReg = st.accumulatorReg;
    assign flags          = st.flags;
    assign prdata         = st.prdata;
    assign pready         = st.pready;
    assign pslverr        = st.pslverr;

    // Operand as selected this cycle, visible to the checks below.
    logic [7:0] operandNow;
    assign operandNow = opImm ? immData : memData;

    // Checks, all in the core clock domain.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstSync);

    // Issue of a given code in a cycle where state advances.
    sequence sIssue(op_t code);
        clkEn && issue && (opCode == code);
    endsequence

    chk_rotate_left_mem: assert property ( // see RULE_01
        sIssue(OP_ROTATE_LEFT) ##0 !opToAcc |=> memWrEn &&
        memWrData == {$past(memData[6:0]), $past(memData[7])} &&
        flags == $past(flags))
        else $error("rotate left result wrong");

    chk_rotate_carry_acc: assert property ( // see RULE_02
        sIssue(OP_ROTATE_LEFT_C) ##0 opToAcc |=> !memWrEn &&
        accumulatorReg == {$past(memData[6:0]), $past(flags[0])} &&
        flags[`FLAG_CARRY] == $past(memData[7]) &&
        flags[5:1] == $past(flags[5:1]))
        else $error("rotate left through carry wrong");

    chk_rotate_right_acc: assert property ( // see RULE_03
        sIssue(OP_ROTATE_RIGHT) ##0 opToAcc |=> !memWrEn &&
        accumulatorReg == {$past(memData[0]), $past(memData[7:1])})
        else $error("rotate right result wrong");

    chk_rotate_right_carry: assert property ( // see RULE_04
        sIssue(OP_ROTATE_RIGHT_C) |=>
        flags[`FLAG_CARRY] == $past(memData[0]))
        else $error("rotate right carry wrong");

    chk_borrow_to_mem: assert property ( // see RULE_07
        sIssue(OP_SUBTRACT_BORROW) ##0 !opToAcc && !opImm |=> memWrEn &&
        accumulatorReg == $past(accumulatorReg) &&
        memWrData == 8'($past(accumulatorReg) - $past(memData)
                        - {7'h00, ~$past(flags[0])}))
        else $error("borrow subtract to memory wrong");

    chk_carry_polarity: assert property ( // see RULE_08
        sIssue(OP_SUBTRACT_PLAIN) |=>
        flags[`FLAG_CARRY] == ($past(accumulatorReg) >= $past(operandNow)))
        else $error("subtract carry polarity wrong");

    chk_decrement_skip: assert property ( // see RULE_10
        sIssue(OP_DECREMENT_SKIP) ##0 (memData == `BYTE_ONE) ##0 !opToAcc
        |=> memWrEn && memWrData == `BYTE_ZERO && skipNext && dummyIns
        ##1 opReady && !dummyIns)
        else $error("decrement and skip wrong");

    chk_increment_noskip: assert property ( // see RULE_13
        sIssue(OP_INCREMENT_SKIP) ##0 (memData != `BYTE_ALL_ONES)
        |=> !skipNext && !dummyIns && !opReady)
        else $error("increment skip taken wrongly");

    chk_set_byte: assert property ( // see RULE_15
        sIssue(OP_SET_BYTE) |=> memWrEn && memWrData == `BYTE_ALL_ONES &&
        flags == $past(flags))
        else $error("set byte wrong");

    chk_skip_nonzero: assert property ( // see RULE_17
        sIssue(OP_SKIP_NZ_BYTE) |=> !memWrEn &&
        skipNext == ($past(memData) != `BYTE_ZERO))
        else $error("skip on non-zero wrong");

    chk_swap_nibbles: assert property ( // see RULE_18
        sIssue(OP_SWAP_NIBBLES) |=> memWrEn &&
        memWrData == {$past(memData[3:0]), $past(memData[7:4])} &&
        flags == $past(flags))
        else $error("nibble swap wrong");

endmodule

// ===== rotate_subtract_skip_alu_defines.svh
// Purpose: Offsets, field positions, reset values and constants of the
//          rotate, subtract and skip datapath.
// Assumes: Included by its bare name from the package and the datapath.
// Notes:   Definitions only; offsets, flag positions, reset values and data constants live here.
`ifndef ROTATE_SUBTRACT_SKIP_ALU_DEFINES_SVH
`define ROTATE_SUBTRACT_SKIP_ALU_DEFINES_SVH

// APB byte offsets of the register words.
`define OFS_ACCUMULATOR   8'h00
`define OFS_FLAGS         8'h04
`define OFS_CONTROL       8'h08
`define OFS_SKIP_COUNT    8'h0C

// Bit positions inside the flag register.
`define FLAG_CARRY        0
`define FLAG_AUX_CARRY    1
`define FLAG_ZERO         2
`define FLAG_OVERFLOW     3
`define FLAG_SIGNED_CARRY 4
`define FLAG_COMB_ZERO    5
`define FLAG_WIDTH        6

// Bit position of the enable inside the control register.
`define CTRL_ENABLE       0

// Reset values.
`define RST_ACCUMULATOR   8'h00
`define RST_FLAGS         6'h00
`define RST_ENABLE        1'h1
`define RST_SKIP_COUNT    8'h00

// Data constants.
`define BYTE_ALL_ONES     8'hFF
`define BYTE_ZERO         8'h00
`define BYTE_ONE          8'h01
`define WORD_ZERO         32'h00000000

`endif

// ===== rotate_subtract_skip_alu_pkg.sv
// Purpose: Types shared by the datapath and whoever drives it.
// Assumes: The decoder issues one operation code with its modifiers.
// Notes:   Constants live in the defines header, types live here.
`include "rotate_subtract_skip_alu_defines.svh"

package rotate_subtract_skip_alu_pkg;

    // Operation codes accepted from the instruction decoder.
    typedef enum logic [3:0] {
        OP_NONE             = 4'h0,
        OP_ROTATE_LEFT      = 4'h1,
        OP_ROTATE_LEFT_C    = 4'h2,
        OP_ROTATE_RIGHT     = 4'h3,
        OP_ROTATE_RIGHT_C   = 4'h4,
        OP_SUBTRACT_BORROW  = 4'h5,
        OP_SUBTRACT_PLAIN   = 4'h6,
        OP_DECREMENT_SKIP   = 4'h7,
        OP_INCREMENT_SKIP   = 4'h8,
        OP_SET_BYTE         = 4'h9,
        OP_SET_BIT          = 4'hA,
        OP_SKIP_NZ_BYTE     = 4'hB,
        OP_SKIP_NZ_BIT      = 4'hC,
        OP_SWAP_NIBBLES     = 4'hD
    } op_t;

    // Sequencer phase; Gray coded along the issue, second-cycle path.
    typedef enum logic [1:0] {
        PH_ISSUE  = 2'h0,
        PH_SECOND = 2'h1
    } phase_t;

    // Whole state of the datapath, registered in one place.
    typedef struct packed {
        phase_t                   phase;
        logic [7:0]               accumulatorReg;
        logic [`FLAG_WIDTH-1:0]   flags;
        logic                     enable;
        logic [7:0]               skipCount;
        logic                     memWrEn;
        logic [7:0]               memWrData;
        logic                     skipNext;
        logic                     dummyIns;
        logic                     opReady;
        logic                     pready;
        logic [31:0]              prdata;
        logic                     pslverr;
    } alu_state_t;

endpackage

// ===== rotate_subtract_skip_alu_tb.sv
// Purpose: Self-checking bench of the rotate, subtract and skip datapath.
// Assumes: Expected results come from a reference written from the rules.
// Notes:   The freeze input is dropped for one offered operation only.
`include "rotate_subtract_skip_alu_defines.svh"
`define CHK(nm, e, g) begin nTests++; if ((e) !== (g)) begin numErrors++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module rotate_subtract_skip_alu_tb;
    import rotate_subtract_skip_alu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rst_n = 0, opValid = 0, opToAcc = 0, opImm = 0;
    logic psel = 0, penable = 0, pwrite = 0, clkEn = 1, wr, sk, du, rd, e;
    op_t opCode = OP_NONE;
    logic [2:0] bitSel = 0;
    logic [3:0] addr = 0;
    logic [7:0] immData = 0, paddr = 0, memData, memWrData, wd, cnt = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic [7:0] accumulatorReg;
    logic [5:0] flags;
    logic [23:0] r;
    logic opReady, memWrEn, skipNext, dummyIns, pready, pslverr;
    int numErrors = 0, nTests = 0;
    localparam logic [7:0] MV [6] = '{8'h00, 8'h01, 8'h81, 8'h7F, 8'hFF,
        8'h10};
    localparam logic [7:0] AV [6] = '{8'h00, 8'h80, 8'h05, 8'hFF, 8'h7F,
        8'h10};
    localparam logic [5:0] FV [6] = '{6'h00, 6'h21, 6'h3F, 6'h20, 6'h01,
        6'h1E};
    always #2 core_clk = ~core_clk;
    rotate_subtract_skip_alu i_rotate_subtract_skip_alu (.core_clk(core_clk),
        .rst_n(rst_n), .clkEn(clkEn), .opValid(opValid), .opCode(opCode),
        .opToAcc(opToAcc), .opImm(opImm), .bitSel(bitSel), .memData(memData),
        .immData(immData), .opReady(opReady), .memWrEn(memWrEn),
        .memWrData(memWrData), .skipNext(skipNext), .dummyIns(dummyIns),
        .accumulatorReg(accumulatorReg), .flags(flags), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    data_memory_model i_data_memory_model (.core_clk(core_clk),
        .opIssue(opValid & opReady), .addr(addr), .memWrEn(memWrEn),
        .memWrData(memWrData), .memData(memData));
    // Reference result packed as skip, write, memory byte, accumulator, flags.
    function automatic logic [23:0] refOp(op_t c, logic ta, im,
        logic [2:0] bs, logic [7:0] a, logic [5:0] f, logic [7:0] m, x);
        logic [8:0] d;
        logic [4:0] lo;
        logic [7:0] b, v;
        logic bi, isB, w, s, z, ov;
        isB = (c == OP_SUBTRACT_BORROW);
        b = im ? x : m;
        bi = isB & ~f[0];
        w = 1;
        s = 0;
        v = m;
        d = {1'b0, a} - {1'b0, b} - bi;
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - bi;
        case (c)
            OP_ROTATE_LEFT: v = {m[6:0], m[7]};
            OP_ROTATE_LEFT_C: begin
                v = {m[6:0], f[0]};
                f[0] = m[7];
            end
            OP_ROTATE_RIGHT: v = {m[0], m[7:1]};
            OP_ROTATE_RIGHT_C: begin
                v = {f[0], m[7:1]};
                f[0] = m[0];
            end
            OP_SUBTRACT_BORROW, OP_SUBTRACT_PLAIN: begin
                v = d[7:0];
                z = (v == 8'h00);
                ov = (a[7] ^ b[7]) & (v[7] ^ a[7]);
                ta = ta | im;
                f = {z & (~isB | f[5]), ov ^ v[7], ov, z, ~lo[4], ~d[8]};
            end
            OP_DECREMENT_SKIP: begin
                v = m - 8'h01;
                s = (v == 8'h00);
            end
            OP_INCREMENT_SKIP: begin
                v = m + 8'h01;
                s = (v == 8'h00);
            end
            OP_SET_BYTE: {v, ta} = {8'hFF, 1'b0};
            OP_SET_BIT: {v, ta} = {m | (8'h01 << bs), 1'b0};
            OP_SKIP_NZ_BYTE: {w, s} = {1'b0, m != 8'h00};
            OP_SKIP_NZ_BIT: {w, s} = {1'b0, m[bs]};
            default: {v, ta} = {m[3:0], m[7:4], 1'b0};
        endcase
        return {s, w & ~ta, v, (w & ta) ? v : a, f};
    endfunction
    // One APB transfer; waits for pready, only the watchdog ends a hang.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk);
        penable <= 1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    // Offer one operation and capture the pulses that follow it.
    task automatic runOp(input op_t c, input logic ta, im,
        input logic [2:0] bs, input logic [3:0] ad, input logic [7:0] x);
        @(posedge core_clk);
        {opValid, opCode, opToAcc, opImm} <= {1'b1, c, ta, im};
        {bitSel, addr, immData} <= {bs, ad, x};
        @(posedge core_clk);
        opValid <= 0;
        #1 {wr, wd, sk, du, rd} = {memWrEn, memWrData, skipNext, dummyIns,
            opReady};
        @(posedge core_clk);
        #1;
    endtask
    task automatic tallyAndFinish();
        $display("tests %0d errors %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Watchdog against a hang.
    initial begin
        repeat (30000) @(posedge core_clk);
        numErrors++;
        tallyAndFinish();
    end
    // Main sequence.
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1;
        repeat (4) @(posedge core_clk);
        apb(0, `OFS_CONTROL, 0);
        `CHK("ctrl", 32'h1, q)
        apb(0, 8'h10, 0);
        `CHK("unmapped", 1'b1, e)
        $display("test registers done");
        for (int o = 1; o <= 13; o++) begin
            for (int t = 0; t < 12; t++) begin
                apb(1, `OFS_ACCUMULATOR, {24'h0, AV[t % 6]});
                apb(1, `OFS_FLAGS, {26'h0, FV[t % 6]});
                i_data_memory_model.mem[t % 6] <= MV[t % 6];
                r = refOp(op_t'(o), t[0] ^ (t > 5), t[1], 3'(t), AV[t % 6],
                    FV[t % 6], MV[t % 6], MV[t % 6] ^ 8'h5A);
                runOp(op_t'(o), t[0] ^ (t > 5), t[1], 3'(t), 4'(t % 6),
                    MV[t % 6] ^ 8'h5A);
                cnt += 8'(r[23]);
                `CHK("acc", r[13:6], accumulatorReg)
                `CHK("flags", r[5:0], flags)
                `CHK("wr", r[22], wr)
                if (r[22]) `CHK("wdata", r[21:14], wd)
                `CHK("mem", r[22] ? r[21:14] : MV[t % 6],
                    i_data_memory_model.mem[t % 6])
                `CHK("skip", r[23], sk)
                `CHK("dummy", r[23], du)
                `CHK("ready", !(o inside {7, 8, 11, 12}), rd)
            end
        end
        $display("test operations done");
        apb(1, `OFS_SKIP_COUNT, 32'hFF);
        apb(0, `OFS_SKIP_COUNT, 0);
        `CHK("skips", {24'h0, cnt}, q)
        clkEn <= 0;
        runOp(OP_SET_BYTE, 0, 0, 0, 4'hE, 0);
        `CHK("frozen", 1'b0, wr)
        @(posedge core_clk);
        clkEn <= 1;
        apb(1, `OFS_CONTROL, 0);
        runOp(OP_SET_BYTE, 0, 0, 0, 4'hF, 0);
        `CHK("off", 1'b0, wr)
        $display("test disable done");
        tallyAndFinish();
    end
endmodule
